//--- rtl/irc_pkg.sv
// package with constants and types for the two-wire slave and reference control
package irc_pkg;
   // bit and byte counts
   localparam int unsigned BITS_PER_BYTE = 8;
   localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
   // fixed upper address bits, low three come from strap inputs
   localparam logic [3:0] ADDR_PREFIX = 4'h9;
   // command codes in upper nibble of the command byte
   localparam logic [3:0] CMD_REF_STATIC = 4'h8;
   localparam logic [3:0] CMD_REF_FLEX = 4'h9;
   // high-speed master code upper five bits
   localparam logic [4:0] HS_CODE_TOP = 5'h01;
   // field positions in the 16-bit data word
   localparam int unsigned REF_POWER_SELECT_POS = 4;
   localparam int unsigned FLEX_MODE_SELECT_POS = 14;
   localparam int unsigned FLEX_SUBCODE_MID_POS = 13;
   localparam int unsigned FLEX_SUBCODE_LOW_POS = 12;
   // flexible subcodes on bits 14..12
   localparam logic [2:0] FLEX_ON = 3'h4;
   localparam logic [2:0] FLEX_ALWAYS_ON = 3'h5;
   localparam logic [2:0] FLEX_FORCED_OFF = 3'h6;
   // reset values and channel count
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int unsigned CHANNELS = 8;

   // reference control modes
   typedef enum logic [1:0] {REF_STATIC, REF_FLEX, REF_ALWAYS_ON, REF_FORCED_OFF} irc_mode_type;

   // reference state bundle
   typedef struct packed {
      irc_mode_type mode;
      logic enabled;
   } irc_ref_type;

   // one decoded write passed to the reference controller
   typedef struct packed {
      logic valid;
      logic [3:0] command;
      logic [15:0] data;
   } irc_cmd_type;
endpackage : irc_pkg

//--- rtl/irc_ref_ctrl.sv
// reference power control: static and flexible modes
`timescale 1ns/1ps
module irc_ref_ctrl
   import irc_pkg::*;
(
   input wire logic refClk,
   input wire logic reset,
   input wire irc_cmd_type cmdIn,
   input wire logic [CHANNELS-1:0] chanPowered,
   output irc_ref_type refState,
   output logic refEnable
);
   irc_ref_type state_r; // current mode and enable
   irc_ref_type state_nxt; // next mode and enable
   logic refEnable_r; // registered enable output
   logic refEnable_nxt; // next enable
   logic [2:0] sub; // flexible subcode bits 14..12

   // decode command into next mode
   always_comb
   begin
      state_nxt = state_r;
      sub = cmdIn.data[FLEX_MODE_SELECT_POS:FLEX_SUBCODE_LOW_POS];
      if (cmdIn.valid && cmdIn.command == CMD_REF_FLEX)
      begin
         if (!cmdIn.data[FLEX_MODE_SELECT_POS])
         begin
            state_nxt.mode = REF_STATIC;
         end
         else if (sub == FLEX_ON)
         begin
            state_nxt.mode = REF_FLEX;
            state_nxt.enabled = 1'b1;
         end
         else if (sub == FLEX_ALWAYS_ON)
         begin
            state_nxt.mode = REF_ALWAYS_ON;
            state_nxt.enabled = 1'b1;
         end
         else if (sub == FLEX_FORCED_OFF && !cmdIn.data[REF_POWER_SELECT_POS])
         begin
            state_nxt.mode = REF_FORCED_OFF;
            state_nxt.enabled = 1'b0;
         end
      end
      else if (cmdIn.valid && cmdIn.command == CMD_REF_STATIC && state_r.mode == REF_STATIC)
      begin
         // flexible modes ignore static writes
         state_nxt.enabled = cmdIn.data[REF_POWER_SELECT_POS];
      end
   end

   // output: follows channel power unless locked
   always_comb
   begin
      unique case (state_nxt.mode)
         REF_ALWAYS_ON: refEnable_nxt = 1'b1;
         REF_FORCED_OFF: refEnable_nxt = 1'b0;
         default: refEnable_nxt = state_nxt.enabled && (|chanPowered);
      endcase
   end

   // register state, off at reset
   always_ff @(posedge refClk)
   begin
      if (reset)
      begin
         state_r <= '{mode: REF_STATIC, enabled: 1'b0};
         refEnable_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         refEnable_r <= refEnable_nxt;
      end
   end

   assign refState = state_r;
   assign refEnable = refEnable_r;

   a_static_ignored: assert property (@(posedge refClk) disable iff (reset)
      (cmdIn.valid && cmdIn.command == CMD_REF_STATIC && state_r.mode != REF_STATIC)
      |=> $stable(state_r))
      else $error("static write changed flexible state");
   a_forced_off: assert property (@(posedge refClk) disable iff (reset)
      (state_r.mode == REF_FORCED_OFF) |-> !refEnable_r)
      else $error("reference on while forced off");
   a_always_on: assert property (@(posedge refClk) disable iff (reset)
      (state_r.mode == REF_ALWAYS_ON) |-> refEnable_r)
      else $error("reference off while locked on");
   a_follow_chan: assert property (@(posedge refClk) disable iff (reset)
      (state_r.mode inside {REF_STATIC, REF_FLEX} && !$past(reset))
      |-> refEnable_r == (state_r.enabled && |$past(chanPowered)))
      else $error("reference not following channel power");
   a_reset_off: assert property (@(posedge refClk) $past(reset) |-> !refEnable_r)
      else $error("reference on after reset");
   a_flex_return: assert property (@(posedge refClk) disable iff (reset)
      (cmdIn.valid && cmdIn.command == CMD_REF_FLEX && !cmdIn.data[FLEX_MODE_SELECT_POS])
      |=> state_r.mode == REF_STATIC)
      else $error("no return to static mode");
endmodule : irc_ref_ctrl

//--- rtl/irc_i2c_slave.sv
// two-wire slave front end with reference control
`timescale 1ns/1ps
module irc_i2c_slave
   import irc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [2:0] addrPins,
   input wire logic [CHANNELS-1:0] chanPowered,
   output logic refEnable,
   output logic hsMode,
   output logic busBusy
);
   // bus phases
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_ACK_RX, ST_ACK_TX, ST_IGNORE}
      irc_state_type;

   logic [1:0] sclSync_r; // two-stage synchroniser for clock pin
   logic [1:0] sdaSync_r; // two-stage synchroniser for data pin
   logic sclPrev_r; // previous synchronised clock
   logic sdaPrev_r; // previous synchronised data
   logic sclRise, sclFall, startSeen, stopSeen; // bus events

   irc_state_type state_r, state_nxt; // bus phase
   logic [3:0] bitCnt_r, bitCnt_nxt; // bit index in the byte
   logic [7:0] shift_r, shift_nxt; // shift register
   logic [1:0] byteIdx_r, byteIdx_nxt; // 0 command, 1 upper, 2 lower payload
   logic [3:0] command_r, command_nxt; // command_access_byte upper nibble
   logic [7:0] upper_r, upper_nxt; // upper_payload_byte
   logic readDir_r, readDir_nxt; // direction of the current transfer
   logic ackLow_r, ackLow_nxt; // we drive acknowledge low
   logic applyPend_r, applyPend_nxt; // apply at end of acknowledge
   logic sdaOut_r, sdaOut_nxt; // data pin output value
   logic sdaOe_r, sdaOe_nxt; // data pin enable, low drives
   logic hsMode_r, hsMode_nxt; // high-speed entry seen
   logic busBusy_r, busBusy_nxt; // between start and stop
   logic [15:0] readWord_r, readWord_nxt; // word under transmission
   logic [5:0] addrSync_r; // two synchroniser stages for the address straps
   logic [2:0] myAddrLow_r; // address straps caught after reset
   logic strapDone_r; // straps captured
   irc_cmd_type cmd_r, cmd_nxt; // pulse to reference control
   irc_ref_type refState; // reference state for read back
   logic [15:0] lastWord_r, lastWord_nxt; // last written payload

   // synchronise the pins, second stage feeds logic
   always_ff @(posedge ref_clk)
   begin
      addrSync_r <= {addrSync_r[2:0], addrPins}; // straps pass two stages, no reset
      if (reset)
      begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end
      else
      begin
         sclSync_r <= {sclSync_r[0], sclIn};
         sdaSync_r <= {sdaSync_r[0], sdaIn};
         sclPrev_r <= sclSync_r[1];
         sdaPrev_r <= sdaSync_r[1];
      end
   end

   // edge and condition detection; works at any rate well below the clock
   always_comb
   begin
      sclRise = sclSync_r[1] && !sclPrev_r;
      sclFall = !sclSync_r[1] && sclPrev_r;
      startSeen = sclSync_r[1] && sclPrev_r && sdaPrev_r && !sdaSync_r[1];
      stopSeen = sclSync_r[1] && sclPrev_r && !sdaPrev_r && sdaSync_r[1];
   end

   // catch address straps once after reset release
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         strapDone_r <= 1'b0;
         myAddrLow_r <= 3'h0;
      end
      else if (!strapDone_r)
      begin
         strapDone_r <= 1'b1;
         myAddrLow_r <= addrSync_r[5:3];
      end
   end

   // bus protocol next state
   always_comb
   begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      byteIdx_nxt = byteIdx_r;
      command_nxt = command_r;
      upper_nxt = upper_r;
      readDir_nxt = readDir_r;
      ackLow_nxt = ackLow_r;
      applyPend_nxt = applyPend_r;
      sdaOut_nxt = sdaOut_r;
      sdaOe_nxt = sdaOe_r;
      hsMode_nxt = hsMode_r;
      busBusy_nxt = busBusy_r;
      readWord_nxt = readWord_r;
      lastWord_nxt = lastWord_r;
      cmd_nxt = cmd_r;
      cmd_nxt.valid = 1'b0;
      if (stopSeen)
      begin
         state_nxt = ST_IDLE;
         sdaOe_nxt = 1'b1;
         busBusy_nxt = 1'b0;
         hsMode_nxt = 1'b0;
         applyPend_nxt = 1'b0;
      end
      else if (startSeen)
      begin
         state_nxt = ST_ADDR;
         bitCnt_nxt = 4'h0;
         sdaOe_nxt = 1'b1;
         busBusy_nxt = 1'b1;
         applyPend_nxt = 1'b0;
      end
      else if (sclRise)
      begin
         // sample on rising clock; data is stable while high
         if (state_r inside {ST_ADDR, ST_RX})
         begin
            shift_nxt = {shift_r[6:0], sdaSync_r[1]};
            bitCnt_nxt = bitCnt_r + 4'h1;
         end
         else if (state_r == ST_ACK_TX)
         begin
            if (sdaSync_r[1])
            begin
               state_nxt = ST_IGNORE; // master refused, stop sending
            end
         end
      end
      else if (sclFall)
      begin
         unique case (state_r)
            ST_ADDR:
            begin
               if (bitCnt_r == 4'(BITS_PER_BYTE))
               begin
                  bitCnt_nxt = 4'h0;
                  if (shift_r[7:3] == HS_CODE_TOP)
                  begin
                     hsMode_nxt = 1'b1;
                     state_nxt = ST_IGNORE;
                  end
                  else if (shift_r[7:1] == {ADDR_PREFIX, myAddrLow_r})
                  begin
                     readDir_nxt = shift_r[0];
                     state_nxt = ST_ACK_RX;
                     ackLow_nxt = 1'b1;
                     sdaOut_nxt = 1'b0;
                     sdaOe_nxt = 1'b0;
                     byteIdx_nxt = 2'h0;
                     readWord_nxt = (command_r == CMD_REF_FLEX || command_r == CMD_REF_STATIC)
                        ? {9'h000, refState.mode == REF_STATIC ? 2'h0 : 2'h1,
                           refState.mode, refState.enabled, 2'h0} : lastWord_r;
                  end
                  else
                  begin
                     state_nxt = ST_IGNORE;
                  end
               end
            end
            ST_RX:
            begin
               if (bitCnt_r == 4'(BITS_PER_BYTE))
               begin
                  bitCnt_nxt = 4'h0;
                  state_nxt = ST_ACK_RX;
                  sdaOut_nxt = 1'b0;
                  sdaOe_nxt = 1'b0;
                  unique case (byteIdx_r)
                     2'h0: begin command_nxt = shift_r[7:4]; byteIdx_nxt = 2'h1; end
                     2'h1: begin upper_nxt = shift_r; byteIdx_nxt = 2'h2; end
                     default:
                     begin
                        applyPend_nxt = 1'b1;
                        byteIdx_nxt = 2'h1; // later words reuse the command
                        lastWord_nxt = {upper_r, shift_r};
                     end
                  endcase
               end
            end
            ST_ACK_RX:
            begin
               sdaOe_nxt = 1'b1; // release after ninth clock
               if (applyPend_r)
               begin
                  cmd_nxt = '{valid: 1'b1, command: command_r, data: lastWord_r};
                  applyPend_nxt = 1'b0;
               end
               if (readDir_r && byteIdx_r == 2'h0 && ackLow_r)
               begin
                  state_nxt = ST_TX;
                  sdaOut_nxt = readWord_r[15];
                  sdaOe_nxt = 1'b0;
                  readWord_nxt = {readWord_r[14:0], 1'b0};
                  bitCnt_nxt = 4'h1;
               end
               else
               begin
                  state_nxt = ST_RX;
               end
               ackLow_nxt = 1'b0;
            end
            ST_TX:
            begin
               if (bitCnt_r == 4'(BITS_PER_BYTE))
               begin
                  state_nxt = ST_ACK_TX; // release for master acknowledge
                  sdaOe_nxt = 1'b1;
                  bitCnt_nxt = 4'h0;
               end
               else
               begin
                  sdaOut_nxt = readWord_r[15];
                  sdaOe_nxt = !(readWord_r[15] == 1'b0);
                  readWord_nxt = {readWord_r[14:0], 1'b0};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end
            end
            ST_ACK_TX:
            begin
               state_nxt = ST_TX;
               sdaOut_nxt = readWord_r[15];
               sdaOe_nxt = readWord_r[15];
               readWord_nxt = {readWord_r[14:0], 1'b0};
               bitCnt_nxt = 4'h1;
            end
            default: ;
         endcase
      end
   end

   // register bus protocol state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= BYTE_RESET;
         byteIdx_r <= 2'h0;
         command_r <= 4'h0;
         upper_r <= BYTE_RESET;
         readDir_r <= 1'b0;
         ackLow_r <= 1'b0;
         applyPend_r <= 1'b0;
         sdaOut_r <= 1'b1;
         sdaOe_r <= 1'b1;
         hsMode_r <= 1'b0;
         busBusy_r <= 1'b0;
         readWord_r <= WORD_RESET;
         lastWord_r <= WORD_RESET;
         cmd_r <= '{valid: 1'b0, command: 4'h0, data: WORD_RESET};
      end
      else
      begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         byteIdx_r <= byteIdx_nxt;
         command_r <= command_nxt;
         upper_r <= upper_nxt;
         readDir_r <= readDir_nxt;
         ackLow_r <= ackLow_nxt;
         applyPend_r <= applyPend_nxt;
         sdaOut_r <= sdaOut_nxt;
         sdaOe_r <= sdaOe_nxt;
         hsMode_r <= hsMode_nxt;
         busBusy_r <= busBusy_nxt;
         readWord_r <= readWord_nxt;
         lastWord_r <= lastWord_nxt;
         cmd_r <= cmd_nxt;
      end
   end

   // reference power controller
   irc_ref_ctrl refCtrl (
      .refClk(ref_clk),
      .reset(reset),
      .cmdIn(cmd_r),
      .chanPowered(chanPowered),
      .refState(refState),
      .refEnable(refEnable)
   );

   assign sdaOut = sdaOut_r;
   assign sdaOe = sdaOe_r;
   assign hsMode = hsMode_r;
   assign busBusy = busBusy_r;

   a_stop_release: assert property (@(posedge ref_clk) disable iff (reset)
      stopSeen |=> sdaOe_r && state_r == ST_IDLE)
      else $error("bus not released on stop");
   a_no_hs_ack: assert property (@(posedge ref_clk) disable iff (reset)
      (state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 && shift_r[7:3] == HS_CODE_TOP)
      |=> sdaOe_r && hsMode_r)
      else $error("master code acknowledged");
   a_write_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
      (!sdaOe_r && state_r inside {ST_RX, ST_ADDR}) |-> 1'b0)
      else $error("data driven while receiving");
   a_ack_match: assert property (@(posedge ref_clk) disable iff (reset)
      (state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 && shift_r[7:1] != {ADDR_PREFIX,
         myAddrLow_r}) |=> sdaOe_r)
      else $error("acknowledged foreign address");
   a_apply_ack_end: assert property (@(posedge ref_clk) disable iff (reset)
      cmd_r.valid |-> $past(state_r) == ST_ACK_RX && $past(sclFall))
      else $error("command applied outside acknowledge end");
endmodule : irc_i2c_slave

//--- testbench/irc_bus_master.sv
// two-wire bus master model that drives clock and data toward the slave
`timescale 1ns/1ps
module irc_bus_master
   import irc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sdaWire,
   output logic sclLine,
   output logic sdaLow
);
   // bus idles with both lines high: data released to the pull-up, clock driven high by the model
   initial
   begin
      sclLine = 1'b1;
      sdaLow = 1'b0;
   end

   // wait a number of clock cycles
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // start or repeated start, clock is left low
   task automatic start();
      sdaLow <= 1'b0;
      tick(2);
      sclLine <= 1'b1;
      tick(4);
      sdaLow <= 1'b1;
      tick(4);
      sclLine <= 1'b0;
      tick(2);
   endtask : start

   // stop, both lines end released
   task automatic stop();
      sdaLow <= 1'b1;
      tick(2);
      sclLine <= 1'b1;
      tick(4);
      sdaLow <= 1'b0;
      tick(4);
   endtask : stop

   // nine clocks at the slow rate; a one in tx releases data, rx is the wire seen
   task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         // data moves only in the low phase of the clock
         sdaLow <= ~tx[i];
         tick(2);
         sclLine <= 1'b1;
         tick(3);
         // sampled late in the high phase, one cycle before the clock falls
         rx[i] = sdaWire;
         tick(1);
         sclLine <= 1'b0;
         tick(2);
      end
   endtask : xfer9
endmodule : irc_bus_master

//--- testbench/test_irc_i2c_slave.sv
// self-checking bench for the two-wire slave and reference control
`timescale 1ns/1ps
module test_irc_i2c_slave
   import irc_pkg::*;
;
   localparam logic [2:0] STRAP = 3'h5; // strap value for the low address bits
   localparam logic [7:0] ADDR_W = {ADDR_PREFIX, STRAP, 1'b0}; // own address, write
   logic ref_clk;
   logic reset;
   logic sdaOut;
   logic sdaOe;
   logic [2:0] addrPins;
   logic [CHANNELS-1:0] chanPowered;
   logic refEnable;
   logic hsMode;
   logic busBusy;
   logic sclLine; // clock from the master model
   logic sdaLow; // master pulls data low
   logic sdaWire; // resolved open-drain data line
   int error_cnt;
   int checked;

   // pull-up wins unless a party pulls the line low
   assign sdaWire = ~(sdaLow | (~sdaOe & ~sdaOut));

   irc_i2c_slave i_irc_i2c_slave (.ref_clk(ref_clk), .reset(reset), .sclIn(sclLine),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPins(addrPins),
      .chanPowered(chanPowered), .refEnable(refEnable), .hsMode(hsMode), .busBusy(busBusy));
   irc_bus_master i_irc_bus_master (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclLine(sclLine),
      .sdaLow(sdaLow));

   // free-running clock at 125 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // compare one value, count and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // print counts and verdict, then end the run
   task automatic summarize();
      $display("errors %0d, comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   // hold reset four cycles and look at the idle outputs
   task automatic do_reset();
      reset <= 1'b1;
      i_irc_bus_master.tick(4);
      check({sdaOe, sdaOut, refEnable, hsMode, busBusy}, 16'h0018);
      reset <= 1'b0;
      i_irc_bus_master.tick(6);
   endtask : do_reset

   // start, own address for writing, then a command byte
   task automatic open_cmd(input logic [7:0] cmd);
      logic [8:0] rx;
      i_irc_bus_master.start();
      check(busBusy, 1'b1);
      i_irc_bus_master.xfer9({ADDR_W, 1'b1}, rx);
      check(rx, {ADDR_W, 1'b0});
      i_irc_bus_master.xfer9({cmd, 1'b1}, rx);
      check(rx, {cmd, 1'b0});
   endtask : open_cmd

   // upper then lower byte; the reference may move only after the last ack
   task automatic send_pair(input logic [15:0] word);
      logic [8:0] rx;
      logic old;
      old = refEnable;
      i_irc_bus_master.xfer9({word[15:8], 1'b1}, rx);
      check(rx, {word[15:8], 1'b0});
      i_irc_bus_master.xfer9({word[7:0], 1'b1}, rx);
      check(rx, {word[7:0], 1'b0});
      check(refEnable, old);
      i_irc_bus_master.tick(6);
   endtask : send_pair

   // one whole command transfer and the enable seen after the stop
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] word, input logic exp);
      open_cmd(cmd);
      send_pair(word);
      i_irc_bus_master.stop();
      check(busBusy, 1'b0);
      check(refEnable, exp);
   endtask : write_word

   // foreign address, general call, ten-bit prefix and master code are not acknowledged
   task automatic t_refused();
      logic [7:0] codes [4] = '{8'h9c, 8'h00, 8'hf0, 8'h08};
      logic [8:0] rx;
      foreach (codes[i])
      begin
         i_irc_bus_master.start();
         i_irc_bus_master.xfer9({codes[i], 1'b1}, rx);
         check(rx, {codes[i], 1'b1});
         check(hsMode, codes[i][7:3] == HS_CODE_TOP);
         i_irc_bus_master.stop();
         check({busBusy, hsMode, sdaOe}, 16'h0001);
      end
   endtask : t_refused

   // static writes, pairs reusing the command byte, channel following
   task automatic t_static();
      write_word(8'h80, 16'h0010, 1'b1);
      open_cmd(8'h80);
      send_pair(16'hffef);
      check(refEnable, 1'b0);
      send_pair(16'h0010);
      check(refEnable, 1'b1);
      i_irc_bus_master.stop();
      chanPowered <= '0;
      i_irc_bus_master.tick(4);
      check(refEnable, 1'b0);
      chanPowered <= 8'h80;
      i_irc_bus_master.tick(4);
      check(refEnable, 1'b1);
      // any single powered channel keeps the reference up
      for (int i = 0; i < CHANNELS; i++)
      begin
         chanPowered <= 8'(1 << i);
         i_irc_bus_master.tick(4);
         check(refEnable, 1'b1);
      end
   endtask : t_static

   // flexible subcodes and the way back to static
   task automatic t_flex();
      write_word(8'h90, 16'h4000, 1'b1);
      write_word(8'h80, 16'h0000, 1'b1);
      chanPowered <= '0;
      i_irc_bus_master.tick(4);
      check(refEnable, 1'b0);
      write_word(8'h90, 16'h5000, 1'b1);
      chanPowered <= 8'h01;
      i_irc_bus_master.tick(4);
      chanPowered <= '0;
      i_irc_bus_master.tick(4);
      check(refEnable, 1'b1);
      chanPowered <= 8'hff;
      write_word(8'h90, 16'h6010, 1'b1);
      write_word(8'h90, 16'h6000, 1'b0);
      write_word(8'h80, 16'h0010, 1'b0);
      write_word(8'h90, 16'hbfff, 1'b0);
      write_word(8'h80, 16'h0010, 1'b1);
   endtask : t_flex

   // word written, then repeated start and read back with master ack then nack
   task automatic t_read();
      logic [8:0] rx;
      open_cmd(8'h00);
      send_pair(16'ha5c3);
      i_irc_bus_master.start();
      i_irc_bus_master.xfer9({ADDR_W | 8'h01, 1'b1}, rx);
      check(rx[0], 1'b0);
      i_irc_bus_master.xfer9(9'h1fe, rx);
      check(rx, 9'h14a);
      i_irc_bus_master.xfer9(9'h1ff, rx);
      check(rx, 9'h187);
      i_irc_bus_master.stop();
      check({sdaOe, busBusy}, 16'h0002);
      // reference register read back after the command byte alone
      open_cmd(8'h90);
      i_irc_bus_master.start();
      i_irc_bus_master.xfer9({ADDR_W | 8'h01, 1'b1}, rx);
      check(rx[0], 1'b0);
      i_irc_bus_master.xfer9(9'h1fe, rx);
      check(rx, {8'h00, 1'b0});
      i_irc_bus_master.xfer9(9'h1ff, rx);
      check(rx, {1'b0, 2'h0, REF_STATIC, 1'b1, 2'h0, 1'b1});
      i_irc_bus_master.stop();
   endtask : t_read

   // new straps across a mid-run reset move the own address
   task automatic t_strap();
      logic [8:0] rx;
      addrPins <= 3'h2;
      do_reset();
      i_irc_bus_master.start();
      i_irc_bus_master.xfer9({ADDR_PREFIX, 3'h2, 2'h1}, rx);
      check(rx, {ADDR_PREFIX, 3'h2, 2'h0});
      i_irc_bus_master.start();
      i_irc_bus_master.xfer9({ADDR_W, 1'b1}, rx);
      check(rx, {ADDR_W, 1'b1});
      i_irc_bus_master.stop();
      check({busBusy, sdaOe}, 16'h0001);
   endtask : t_strap

   // main sequence
   initial
   begin
      error_cnt = 0;
      checked = 0;
      reset = 1'b1;
      addrPins = STRAP;
      chanPowered = 8'hff;
      do_reset();
      t_refused();
      t_static();
      t_flex();
      t_read();
      t_strap();
      summarize();
   end

   // cut a hang short well past the expected run length
   initial
   begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule : test_irc_i2c_slave
